//--- src/pmc_pad_mux_consts.vh
`ifndef PMC_PAD_MUX_CONSTS_VH
`define PMC_PAD_MUX_CONSTS_VH

// Number of pads in the bank and per-pad widths
`define PMC_PAD_COUNT 41
`define PMC_FUNC_COUNT 16
`define PMC_FUNC_W 4
`define PMC_IDX_W 6
`define PMC_IDX_NONE 6'h3F

// Field positions shared by every pad register
`define PMC_SLEW_CHOICE_BIT 10
`define PMC_PULL_DIRECTION_BIT 9
`define PMC_PULL_DISABLE_BIT 8
`define PMC_OUT_FORCE_VALUE_BIT 7
`define PMC_OUT_FORCE_ON_BIT 6
`define PMC_INPUT_FORCE_VALUE_BIT 5
`define PMC_INPUT_FORCE_ON_BIT 4
`define PMC_FUNC_LSB 0
`define PMC_SPARE_LSB 11

// Reset value: output force on and forced to 1, function choice 1
`define PMC_CFG_RESET 32'h000000C1

// Register byte addresses
`define PMC_ADDR_HOST_IRQ 32'h0FFFEA00
`define PMC_ADDR_GP_IO_ZERO 32'hFFFFEA04
`define PMC_ADDR_GP_IO_ONE 32'hFFFFEA08
`define PMC_ADDR_SERIAL_A_DATA_OUT 32'hFFFFEA0C
`define PMC_ADDR_SERIAL_A_DATA_IN 32'hFFFFEA10
`define PMC_ADDR_SERIAL_A_CLOCK 32'h0FFFEA14
`define PMC_ADDR_SERIAL_A_SELECT 32'hFFFFEA18
`define PMC_ADDR_SERIAL_B_DATA_OUT 32'hFFFFEA1C
`define PMC_ADDR_SERIAL_B_DATA_IN 32'h0FFFEA20
`define PMC_ADDR_SERIAL_B_CLOCK 32'h0FFFEA24
`define PMC_ADDR_SERIAL_B_SELECT 32'h0FFFEA28
`define PMC_ADDR_FLASH_DATA0 32'hFFFFEA2C
`define PMC_ADDR_FLASH_DATA1 32'h0FFFEA30
`define PMC_ADDR_FLASH_DATA2 32'h0FFFEA34
`define PMC_ADDR_FLASH_DATA3 32'h0FFFEA38
`define PMC_ADDR_FLASH_CLOCK 32'hFFFFEA3C
`define PMC_ADDR_FLASH_SELECT 32'h0FFFEA40
`define PMC_ADDR_FAULT_INPUT 32'h0FFFEA44
`define PMC_ADDR_SOFT_RESET_PIN 32'h0FFFEA48
`define PMC_ADDR_FAULT_OUTPUT 32'hFFFFEA4C
`define PMC_ADDR_JTAG_CLOCK 32'h0FFFEA50
`define PMC_ADDR_JTAG_MODE_SELECT 32'h0FFFEA54
`define PMC_ADDR_JTAG_DATA_IN 32'h0FFFEA58
`define PMC_ADDR_JTAG_DATA_OUT 32'hFFFFEA5C
`define PMC_ADDR_CPU_CLOCK_OUT 32'h0FFFEA60
`define PMC_ADDR_GP_IO_TWO 32'h0FFFEA64
`define PMC_ADDR_POWER_CLOCK_OUT 32'h0FFFEA68
`define PMC_ADDR_INBOUND_SYNC 32'h0FFFEA6C
`define PMC_ADDR_OUTBOUND_SYNC 32'h0FFFEA70
`define PMC_ADDR_UART_RECEIVE 32'h0FFFEA74
`define PMC_ADDR_UART_TRANSMIT 32'h0FFFEA78
`define PMC_ADDR_GP_IO_31 32'hFFFFEA7C
`define PMC_ADDR_GP_IO_32 32'h0FFFEA80
`define PMC_ADDR_GP_IO_33 32'h0FFFEA84
`define PMC_ADDR_GP_IO_34 32'h0FFFEA88
`define PMC_ADDR_GP_IO_35 32'h0FFFEA8C
`define PMC_ADDR_GP_IO_36 32'h0FFFEA90
`define PMC_ADDR_GP_IO_37 32'h0FFFEA94
`define PMC_ADDR_GP_IO_38 32'h0FFFEA98
`define PMC_ADDR_GP_IO_47 32'hFFFFEABC
`define PMC_ADDR_DEBUG_CAPTURE_SYNC 32'hFFFFEAC0

`endif

//--- src/pmc_pad_mux_control.v
`timescale 1ns/1ns
`include "pmc_pad_mux_consts.vh"

// Notes on behaviour
// - one read-write register per pad, shared layout
// - bit 10 picks slow slew, resets 0
// - bit 8 disables pull, bit 9 picks up
// - bit 6 forces output enable to the inverse of bit 7
// - bit 4 forces inward value to bit 5
// - bits 3-0 pick the ball function, reset 1
// - function number selects that multiplexed signal
// - registers reachable by ordinary bus accesses
module pmc_pad_mux_control (
  input wire clk_i,
  input wire reset_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [`PMC_PAD_COUNT*`PMC_FUNC_COUNT-1:0] fn_out_i,
  input wire [`PMC_PAD_COUNT*`PMC_FUNC_COUNT-1:0] fn_oe_i,
  input wire [`PMC_PAD_COUNT-1:0] pad_in_i,
  output wire [`PMC_PAD_COUNT-1:0] pad_out_o,
  output wire [`PMC_PAD_COUNT-1:0] pad_oe_o,
  output wire [`PMC_PAD_COUNT-1:0] core_in_o,
  output wire [`PMC_PAD_COUNT-1:0] pad_slow_slew_o,
  output wire [`PMC_PAD_COUNT-1:0] pad_pull_en_o,
  output wire [`PMC_PAD_COUNT-1:0] pad_pull_up_o,
  output wire [`PMC_PAD_COUNT*`PMC_FUNC_W-1:0] pad_func_o
);

  localparam NP = `PMC_PAD_COUNT;

  reg [NP*32-1:0] cfg_r;
  reg [31:0] prdata_r;
  reg pready_r;
  reg pslverr_r;
  reg [NP-1:0] in_meta_r;
  reg [NP-1:0] in_sync_r;
  reg [NP-1:0] pad_out_r;
  reg [NP-1:0] pad_oe_r;
  reg [NP-1:0] core_in_r;
  reg [NP-1:0] pad_out_nxt;
  reg [NP-1:0] pad_oe_nxt;
  reg [NP-1:0] core_in_nxt;
  reg [NP-1:0] pull_en_r;
  reg [`PMC_FUNC_W-1:0] sel;
  reg [31:0] word;
  wire [`PMC_IDX_W-1:0] hit_idx;
  wire hit;
  wire [10:0] rd_base;
  wire setup_phase;
  wire write_access;
  integer i;
  integer b;
  integer j;

  // Pad index of every register, in address-list order
  localparam [5:0] IDX_HOST_IRQ = 6'h00;
  localparam [5:0] IDX_GP_IO_ZERO = 6'h01;
  localparam [5:0] IDX_GP_IO_ONE = 6'h02;
  localparam [5:0] IDX_SERIAL_A_DATA_OUT = 6'h03;
  localparam [5:0] IDX_SERIAL_A_DATA_IN = 6'h04;
  localparam [5:0] IDX_SERIAL_A_CLOCK = 6'h05;
  localparam [5:0] IDX_SERIAL_A_SELECT = 6'h06;
  localparam [5:0] IDX_SERIAL_B_DATA_OUT = 6'h07;
  localparam [5:0] IDX_SERIAL_B_DATA_IN = 6'h08;
  localparam [5:0] IDX_SERIAL_B_CLOCK = 6'h09;
  localparam [5:0] IDX_SERIAL_B_SELECT = 6'h0A;
  localparam [5:0] IDX_FLASH_DATA0 = 6'h0B;
  localparam [5:0] IDX_FLASH_DATA1 = 6'h0C;
  localparam [5:0] IDX_FLASH_DATA2 = 6'h0D;
  localparam [5:0] IDX_FLASH_DATA3 = 6'h0E;
  localparam [5:0] IDX_FLASH_CLOCK = 6'h0F;
  localparam [5:0] IDX_FLASH_SELECT = 6'h10;
  localparam [5:0] IDX_FAULT_INPUT = 6'h11;
  localparam [5:0] IDX_SOFT_RESET_PIN = 6'h12;
  localparam [5:0] IDX_FAULT_OUTPUT = 6'h13;
  localparam [5:0] IDX_JTAG_CLOCK = 6'h14;
  localparam [5:0] IDX_JTAG_MODE_SELECT = 6'h15;
  localparam [5:0] IDX_JTAG_DATA_IN = 6'h16;
  localparam [5:0] IDX_JTAG_DATA_OUT = 6'h17;
  localparam [5:0] IDX_CPU_CLOCK_OUT = 6'h18;
  localparam [5:0] IDX_GP_IO_TWO = 6'h19;
  localparam [5:0] IDX_POWER_CLOCK_OUT = 6'h1A;
  localparam [5:0] IDX_INBOUND_SYNC = 6'h1B;
  localparam [5:0] IDX_OUTBOUND_SYNC = 6'h1C;
  localparam [5:0] IDX_UART_RECEIVE = 6'h1D;
  localparam [5:0] IDX_UART_TRANSMIT = 6'h1E;
  localparam [5:0] IDX_GP_IO_31 = 6'h1F;
  localparam [5:0] IDX_GP_IO_32 = 6'h20;
  localparam [5:0] IDX_GP_IO_33 = 6'h21;
  localparam [5:0] IDX_GP_IO_34 = 6'h22;
  localparam [5:0] IDX_GP_IO_35 = 6'h23;
  localparam [5:0] IDX_GP_IO_36 = 6'h24;
  localparam [5:0] IDX_GP_IO_37 = 6'h25;
  localparam [5:0] IDX_GP_IO_38 = 6'h26;
  localparam [5:0] IDX_GP_IO_47 = 6'h27;
  localparam [5:0] IDX_DEBUG_CAPTURE_SYNC = 6'h28;

  // Both address bases are decoded in full; no aliasing between them
  function [`PMC_IDX_W-1:0] pmc_decode;
    input [31:0] addr;
    begin
      case (addr)
        `PMC_ADDR_HOST_IRQ: begin
          pmc_decode = IDX_HOST_IRQ;
        end
        `PMC_ADDR_GP_IO_ZERO: begin
          pmc_decode = IDX_GP_IO_ZERO;
        end
        `PMC_ADDR_GP_IO_ONE: begin
          pmc_decode = IDX_GP_IO_ONE;
        end
        `PMC_ADDR_SERIAL_A_DATA_OUT: begin
          pmc_decode = IDX_SERIAL_A_DATA_OUT;
        end
        `PMC_ADDR_SERIAL_A_DATA_IN: begin
          pmc_decode = IDX_SERIAL_A_DATA_IN;
        end
        `PMC_ADDR_SERIAL_A_CLOCK: begin
          pmc_decode = IDX_SERIAL_A_CLOCK;
        end
        `PMC_ADDR_SERIAL_A_SELECT: begin
          pmc_decode = IDX_SERIAL_A_SELECT;
        end
        `PMC_ADDR_SERIAL_B_DATA_OUT: begin
          pmc_decode = IDX_SERIAL_B_DATA_OUT;
        end
        `PMC_ADDR_SERIAL_B_DATA_IN: begin
          pmc_decode = IDX_SERIAL_B_DATA_IN;
        end
        `PMC_ADDR_SERIAL_B_CLOCK: begin
          pmc_decode = IDX_SERIAL_B_CLOCK;
        end
        `PMC_ADDR_SERIAL_B_SELECT: begin
          pmc_decode = IDX_SERIAL_B_SELECT;
        end
        `PMC_ADDR_FLASH_DATA0: begin
          pmc_decode = IDX_FLASH_DATA0;
        end
        `PMC_ADDR_FLASH_DATA1: begin
          pmc_decode = IDX_FLASH_DATA1;
        end
        `PMC_ADDR_FLASH_DATA2: begin
          pmc_decode = IDX_FLASH_DATA2;
        end
        `PMC_ADDR_FLASH_DATA3: begin
          pmc_decode = IDX_FLASH_DATA3;
        end
        `PMC_ADDR_FLASH_CLOCK: begin
          pmc_decode = IDX_FLASH_CLOCK;
        end
        `PMC_ADDR_FLASH_SELECT: begin
          pmc_decode = IDX_FLASH_SELECT;
        end
        `PMC_ADDR_FAULT_INPUT: begin
          pmc_decode = IDX_FAULT_INPUT;
        end
        `PMC_ADDR_SOFT_RESET_PIN: begin
          pmc_decode = IDX_SOFT_RESET_PIN;
        end
        `PMC_ADDR_FAULT_OUTPUT: begin
          pmc_decode = IDX_FAULT_OUTPUT;
        end
        `PMC_ADDR_JTAG_CLOCK: begin
          pmc_decode = IDX_JTAG_CLOCK;
        end
        `PMC_ADDR_JTAG_MODE_SELECT: begin
          pmc_decode = IDX_JTAG_MODE_SELECT;
        end
        `PMC_ADDR_JTAG_DATA_IN: begin
          pmc_decode = IDX_JTAG_DATA_IN;
        end
        `PMC_ADDR_JTAG_DATA_OUT: begin
          pmc_decode = IDX_JTAG_DATA_OUT;
        end
        `PMC_ADDR_CPU_CLOCK_OUT: begin
          pmc_decode = IDX_CPU_CLOCK_OUT;
        end
        `PMC_ADDR_GP_IO_TWO: begin
          pmc_decode = IDX_GP_IO_TWO;
        end
        `PMC_ADDR_POWER_CLOCK_OUT: begin
          pmc_decode = IDX_POWER_CLOCK_OUT;
        end
        `PMC_ADDR_INBOUND_SYNC: begin
          pmc_decode = IDX_INBOUND_SYNC;
        end
        `PMC_ADDR_OUTBOUND_SYNC: begin
          pmc_decode = IDX_OUTBOUND_SYNC;
        end
        `PMC_ADDR_UART_RECEIVE: begin
          pmc_decode = IDX_UART_RECEIVE;
        end
        `PMC_ADDR_UART_TRANSMIT: begin
          pmc_decode = IDX_UART_TRANSMIT;
        end
        `PMC_ADDR_GP_IO_31: begin
          pmc_decode = IDX_GP_IO_31;
        end
        `PMC_ADDR_GP_IO_32: begin
          pmc_decode = IDX_GP_IO_32;
        end
        `PMC_ADDR_GP_IO_33: begin
          pmc_decode = IDX_GP_IO_33;
        end
        `PMC_ADDR_GP_IO_34: begin
          pmc_decode = IDX_GP_IO_34;
        end
        `PMC_ADDR_GP_IO_35: begin
          pmc_decode = IDX_GP_IO_35;
        end
        `PMC_ADDR_GP_IO_36: begin
          pmc_decode = IDX_GP_IO_36;
        end
        `PMC_ADDR_GP_IO_37: begin
          pmc_decode = IDX_GP_IO_37;
        end
        `PMC_ADDR_GP_IO_38: begin
          pmc_decode = IDX_GP_IO_38;
        end
        `PMC_ADDR_GP_IO_47: begin
          pmc_decode = IDX_GP_IO_47;
        end
        `PMC_ADDR_DEBUG_CAPTURE_SYNC: begin
          pmc_decode = IDX_DEBUG_CAPTURE_SYNC;
        end
        default: pmc_decode = `PMC_IDX_NONE;
      endcase
    end
  endfunction

  assign hit_idx = pmc_decode(paddr_i);
  assign hit = (hit_idx != `PMC_IDX_NONE);
  assign rd_base = {hit_idx[5:0], 5'h00};
  assign setup_phase = psel_i & ~penable_i;
  assign write_access = psel_i & penable_i & pwrite_i & hit;

  // Register bank; only byte lanes with a strobe are updated
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (i = 0; i < NP; i = i + 1) begin
        cfg_r[i*32 +: 32] <= `PMC_CFG_RESET;
        pull_en_r[i] <= 1'b1;
      end
    end else if (write_access) begin
      for (i = 0; i < NP; i = i + 1) begin
        if (hit_idx == i[5:0]) begin
          for (b = 0; b < 4; b = b + 1) begin
            if (pstrb_i[b]) begin
              cfg_r[i*32 + b*8 +: 8] <= pwdata_i[b*8 +: 8];
            end
          end
          // Kept as its own flop so the enable output needs no inverter
          if (pstrb_i[1]) begin
            pull_en_r[i] <= ~pwdata_i[`PMC_PULL_DISABLE_BIT];
          end
        end
      end
    end
  end

  // Read data and error are captured in the setup cycle, so the slave
  // answers with zero wait states and every output stays a flop
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup_phase) begin
        pslverr_r <= ~hit;
        if (hit && !pwrite_i) begin
          prdata_r <= cfg_r[rd_base +: 32];
        end else begin
          prdata_r <= 32'h00000000;
        end
      end
    end
  end

  // Ball levels come from outside the clock domain
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      in_meta_r <= {NP{1'b0}};
      in_sync_r <= {NP{1'b0}};
    end else begin
      in_meta_r <= pad_in_i;
      in_sync_r <= in_meta_r;
    end
  end

  always @* begin
    sel = {`PMC_FUNC_W{1'b0}};
    word = 32'h00000000;
    pad_out_nxt = {NP{1'b0}};
    pad_oe_nxt = {NP{1'b0}};
    core_in_nxt = {NP{1'b0}};
    for (j = 0; j < NP; j = j + 1) begin
      word = cfg_r[j*32 +: 32];
      sel = word[`PMC_FUNC_LSB +: `PMC_FUNC_W];
      pad_out_nxt[j] = fn_out_i[j*`PMC_FUNC_COUNT + sel];
      if (word[`PMC_OUT_FORCE_ON_BIT]) begin
        // Force value 1 means the driver is off, matching the quiet reset state
        pad_oe_nxt[j] = ~word[`PMC_OUT_FORCE_VALUE_BIT];
      end else begin
        pad_oe_nxt[j] = fn_oe_i[j*`PMC_FUNC_COUNT + sel];
      end
      if (word[`PMC_INPUT_FORCE_ON_BIT]) begin
        core_in_nxt[j] = word[`PMC_INPUT_FORCE_VALUE_BIT];
      end else begin
        core_in_nxt[j] = in_sync_r[j];
      end
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      pad_out_r <= {NP{1'b0}};
      pad_oe_r <= {NP{1'b0}};
      core_in_r <= {NP{1'b0}};
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
      core_in_r <= core_in_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_pad
      assign pad_slow_slew_o[g] = cfg_r[g*32 + `PMC_SLEW_CHOICE_BIT];
      // Pull direction only matters while the pull is enabled
      assign pad_pull_en_o[g] = pull_en_r[g];
      assign pad_pull_up_o[g] = cfg_r[g*32 + `PMC_PULL_DIRECTION_BIT];
      assign pad_func_o[g*`PMC_FUNC_W +: `PMC_FUNC_W] = cfg_r[g*32 +: `PMC_FUNC_W];
    end
  endgenerate

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign pad_out_o = pad_out_r;
  assign pad_oe_o = pad_oe_r;
  assign core_in_o = core_in_r;

endmodule // pmc_pad_mux_control

//--- bench/pmc_pad_peer.sv
`timescale 1ns/1ns
`include "pmc_pad_mux_consts.vh"
module pmc_pad_peer (
  input wire clk_i,
  input wire mode_i,
  output reg [`PMC_PAD_COUNT*`PMC_FUNC_COUNT-1:0] fn_out_o = 0,
  output reg [`PMC_PAD_COUNT*`PMC_FUNC_COUNT-1:0] fn_oe_o = 0,
  output reg [`PMC_PAD_COUNT-1:0] pad_in_o = 0
);
  // Peripherals change just after an edge; the ball level is async to the bank anyway
  always @(posedge clk_i) begin
    fn_out_o <= {`PMC_PAD_COUNT{mode_i ? 16'hA5C3 : 16'h5A3C}};
    fn_oe_o <= {`PMC_PAD_COUNT{16'h0FF0}};
    pad_in_o <= {`PMC_PAD_COUNT{mode_i}};
  end
endmodule // pmc_pad_peer

//--- bench/pmc_pad_mux_asserts.sv
`timescale 1ns/1ns
`include "pmc_pad_mux_consts.vh"
module pmc_pad_mux_asserts (
  input wire clk_i,
  input wire reset_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [`PMC_PAD_COUNT*`PMC_FUNC_COUNT-1:0] fn_out_i,
  input wire [`PMC_PAD_COUNT-1:0] pad_oe_o,
  input wire [`PMC_PAD_COUNT-1:0] pad_out_o,
  input wire [`PMC_PAD_COUNT-1:0] core_in_o,
  input wire [`PMC_PAD_COUNT-1:0] pad_slow_slew_o,
  input wire [`PMC_PAD_COUNT-1:0] pad_pull_en_o,
  input wire [`PMC_PAD_COUNT-1:0] pad_pull_up_o,
  input wire [`PMC_PAD_COUNT*`PMC_FUNC_W-1:0] pad_func_o
);
  wire acc = psel_i & penable_i;
  wire wr0 = acc & pwrite_i & (paddr_i == `PMC_ADDR_HOST_IRQ) & (pstrb_i == 4'hF);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ready; $past(reset_n_i) |-> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_rst; $rose(reset_n_i) |-> pad_func_o == {`PMC_PAD_COUNT{4'h1}} && pad_oe_o == 0
    && pad_slow_slew_o == 0 && pad_pull_up_o == 0 && &pad_pull_en_o; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_slew; wr0 |=> pad_slow_slew_o[0] == $past(pwdata_i[10]); endproperty
  a_slew: assert property (p_slew) else $error("slew wrong");
  property p_pull; wr0 |=> pad_pull_en_o[0] != $past(pwdata_i[8])
    && pad_pull_up_o[0] == $past(pwdata_i[9]); endproperty
  a_pull: assert property (p_pull) else $error("pull wrong");
  property p_func; wr0 |=> pad_func_o[3:0] == $past(pwdata_i[3:0]); endproperty
  a_func: assert property (p_func) else $error("function wrong");
  property p_oe; wr0 && pwdata_i[6] |=> ##1 pad_oe_o[0] == !$past(pwdata_i[7], 2); endproperty
  a_oe: assert property (p_oe) else $error("forced enable wrong");
  property p_inf; wr0 && pwdata_i[4] |=> ##1 core_in_o[0] == $past(pwdata_i[5], 2); endproperty
  a_inf: assert property (p_inf) else $error("forced input wrong");
  property p_mux; $past(reset_n_i) |-> pad_out_o[0] == $past(fn_out_i[pad_func_o[3:0]]); endproperty
  a_mux: assert property (p_mux) else $error("mux wrong");
  property p_rdbk; acc && !pwrite_i && paddr_i == `PMC_ADDR_HOST_IRQ
    |-> prdata_o[3:0] == pad_func_o[3:0] && prdata_o[10] == pad_slow_slew_o[0]; endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback wrong");
  property p_bad; acc && paddr_i == 32'hFFFFEA00 |-> pslverr_o && prdata_o == 32'h0; endproperty
  a_bad: assert property (p_bad) else $error("unmapped not refused");
endmodule // pmc_pad_mux_asserts
bind pmc_pad_mux_control pmc_pad_mux_asserts u_chk (.*);

//--- bench/pad_io_mux_control_test.sv
`timescale 1ns/1ns
`include "pmc_pad_mux_consts.vh"
module pad_io_mux_control_test;
  localparam W = `PMC_PAD_COUNT;
  localparam [15:0] PAT = 16'h5A3C;
  localparam [15:0] OEP = 16'h0FF0;
  reg clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, mode = 0, err;
  reg [31:0] paddr_i = 0, pwdata_i = 0, rd;
  reg [31:0] a [0:5];
  reg [3:0] pstrb_i = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o;
  wire [W*16-1:0] fn_out_i, fn_oe_i;
  wire [W-1:0] pad_in_i, pad_out_o, pad_oe_o, core_in_o, pad_slow_slew_o, pad_pull_en_o, pad_pull_up_o;
  wire [W*4-1:0] pad_func_o;
  integer checks = 0, bad_count = 0, i;
  always #50 clk_i = ~clk_i;
  pmc_pad_peer peer (.clk_i, .mode_i(mode), .fn_out_o(fn_out_i), .fn_oe_o(fn_oe_i), .pad_in_o(pad_in_i));
  pmc_pad_mux_control dut (.*);
  task results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One idle edge before each setup keeps psel from being driven twice in a time step
  task apb(input w, input [31:0] ad, input [31:0] d, input [3:0] s);
    integer n;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n = n + 1;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 20) begin
      bad_count = bad_count + 1;
      results;
    end
  endtask
  task wr(input [31:0] ad, input [31:0] d);
    apb(1'b1, ad, d, 4'hF);
    repeat (2) @(posedge clk_i);
  endtask
  task rdc(input [31:0] ad, input [31:0] e);
    apb(1'b0, ad, 32'h0, 4'h0);
    chk(rd, e);
  endtask
  initial begin
    a[0] = `PMC_ADDR_HOST_IRQ;
    a[1] = `PMC_ADDR_GP_IO_ZERO;
    a[2] = `PMC_ADDR_SERIAL_A_CLOCK;
    a[3] = `PMC_ADDR_JTAG_DATA_OUT;
    a[4] = `PMC_ADDR_GP_IO_38;
    a[5] = `PMC_ADDR_DEBUG_CAPTURE_SYNC;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (i = 0; i < 6; i = i + 1) rdc(a[i], `PMC_CFG_RESET);
    for (i = 0; i < 6; i = i + 1) wr(a[i], 32'hA5A5A000 + i * 32'h111);
    for (i = 0; i < 6; i = i + 1) rdc(a[i], 32'hA5A5A000 + i * 32'h111);
    apb(1'b1, 32'hFFFFEA00, 32'hFFFFFFFF, 4'hF);
    apb(1'b0, 32'hFFFFEA00, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    rdc(a[0], 32'hA5A5A000);
    apb(1'b1, a[1], 32'h00000077, 4'h1);
    rdc(a[1], 32'hA5A5A177);
    for (i = 0; i < 16; i = i + 1) begin
      wr(a[0], i);
      chk(pad_func_o[3:0], i);
      chk(pad_out_o[0], PAT[i]);
      chk(pad_oe_o[0], OEP[i]);
    end
    chk(pad_func_o[7:4], 4'h7);
    mode <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(pad_out_o[0], 1'b1);
    chk(core_in_o[0], 1'b1);
    wr(a[0], 32'h0000004F);
    chk(pad_oe_o[0], 1'b1);
    wr(a[0], 32'h000000C4);
    chk(pad_oe_o[0], 1'b0);
    wr(a[0], 32'h00000014);
    chk(core_in_o[0], 1'b0);
    wr(a[0], 32'h00000604);
    chk({pad_slow_slew_o[0], pad_pull_en_o[0], pad_pull_up_o[0]}, 3'h7);
    wr(a[0], 32'h00000100);
    chk({pad_slow_slew_o[0], pad_pull_en_o[0], pad_pull_up_o[0]}, 3'h0);
    results;
  end
endmodule // pad_io_mux_control_test
